// *** rtl/fcd_defs.vh ***
// register map, field positions and reset values of the four-channel dma
`ifndef FCD_DEFS_VH
`define FCD_DEFS_VH
// per-channel block: byte offset = channel * 0x20 + register offset
`define FCD_CH_STRIDE     12'h020
`define FCD_OFF_CON       12'h000
`define FCD_OFF_REQ       12'h004
`define FCD_OFF_STAL      12'h008
`define FCD_OFF_STAH      12'h00C
`define FCD_OFF_STBL      12'h010
`define FCD_OFF_STBH      12'h014
`define FCD_OFF_PAD       12'h018
`define FCD_OFF_CNT       12'h01C
// shared status
`define FCD_OFF_PWC       12'h080
`define FCD_OFF_RQC       12'h084
`define FCD_OFF_PPS       12'h088
`define FCD_OFF_LCA       12'h08C
`define FCD_OFF_SADRL     12'h090
`define FCD_OFF_SADRH     12'h094
// control fields
`define FCD_CON_ON        15
`define FCD_CON_SIZE      14
`define FCD_CON_DIR       13
`define FCD_CON_HALF      12
`define FCD_CON_NULL_WRITE_MODE     11
`define FCD_CON_ADDRESSING_SELECT_HI   5
`define FCD_CON_ADDRESSING_SELECT_LO   4
`define FCD_CON_MODE_HI   1
`define FCD_CON_MODE_LO   0
`define FCD_CON_MASK      16'hF833
`define FCD_REQ_FORCE     15
`define FCD_ADDRESSING_SELECT_POSTINC  2'h0
`define FCD_ADDRESSING_SELECT_NOINC    2'h1
`define FCD_ADDRESSING_SELECT_PERIND   2'h2
// request codes; the adc and uart1 ones come with documented peripheral addresses
`define FCD_IRQ_CAN_TX    8'h46
`define FCD_IRQ_CAN_RX    8'h22
`define FCD_IRQ_ADC_DONE  8'h0D
`define FCD_IRQ_UART1_TX  8'h0C
`define FCD_PAD_ADC_BUF0  16'h0300
`define FCD_PAD_UART1_TX  16'h0224
`define FCD_LCA_RESET     4'hF
`endif

// *** rtl/fcd_dma.v ***
// four-channel peripheral dma engine with apb register slave
//
// Notes on behaviour
// - four channels, each configured on its own.
// - each channel moves data one way, chosen by its direction bit.
// - lowest-numbered pending channel wins; others stay pending.
// - sram reached through shared arbiter; grant may stall the engine.
// - 24-bit memory address covers the whole data space.
// - block done or half block raises a channel interrupt pulse.
// - post-increment mode advances sram address after each transfer.
// - no-increment mode keeps sram address fixed.
// - peripheral-indirect mode uses the address the peripheral supplies.
// - size bit one selects byte, zero selects word.
// - transfer starts on software force or peripheral request.
// - one-shot stops after a block; continuous restarts.
// - ping-pong swaps primary and secondary start after each block.
// - 8-bit request select picks any interrupt source.
// - can transmit code 01000110, can receive 00100010.
// - converter done code 00001101, reads buffer at 0x0300.
// - uart1 transmit code 00001100, writes data register 0x0224.
// - 14-bit count and 16-bit peripheral address per channel.
// - primary and secondary start; high half keeps bits 7..0 only.
// - shared status: collisions, ping-pong, last channel, last address.
// - force not clearable by software; cleared on completion or disable.
// - interrupt flag, enable and priority live outside this block.
// - transfers per block equal count field plus one.
// - peripheral request arriving while force is set sets request collision flag.
// - last channel reads 1111 until first transfer, then channel number.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defs.vh"
module fcd_dma #(
  parameter NCH = 4
) (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire        i_ce,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire [NCH*8-1:0] i_irq_code,
  input  wire [NCH-1:0]   i_irq_pulse,
  input  wire [NCH*24-1:0] i_per_addr,
  input  wire        i_per_wcol,
  output reg         o_mem_req,
  output reg         o_mem_we,
  output reg         o_mem_byte,
  output reg  [23:0] o_mem_addr,
  output reg  [15:0] o_mem_wdata,
  input  wire        i_mem_gnt,
  input  wire [15:0] i_mem_rdata,
  output reg  [NCH-1:0] o_ch_irq
);
////////////////////////////////////////////////////////////////////////
  localparam S_IDLE = 3'b001;
  localparam S_RD   = 3'b010;
  localparam S_WR   = 3'b100;
  reg [15:0] con_q   [0:NCH-1];
  reg [7:0]  sel_q   [0:NCH-1];
  reg        force_q [0:NCH-1];
  reg [23:0] sta_q   [0:NCH-1];
  reg [23:0] stb_q   [0:NCH-1];
  reg [15:0] pad_q   [0:NCH-1];
  reg [13:0] cnt_q   [0:NCH-1];
  reg [13:0] done_q  [0:NCH-1];
  reg [23:0] off_q   [0:NCH-1];
  reg [NCH-1:0] pend_q;
  reg [NCH-1:0] pps_q;
  reg [NCH-1:0] rqc_q;
  reg [NCH-1:0] pwc_q;
  reg [NCH-1:0] stop_q;
  reg [3:0]  lca_q;
  reg [23:0] sadr_q;
  reg [2:0]  st_q;
  reg [1:0]  act_q;
  reg [15:0] data_q;
  reg [23:0] xa_q;
  reg        xdir_q;
  integer    k;
  wire       apb_acc = i_psel & i_penable & i_ce;
  wire [1:0] ach     = i_paddr[6:5];
  wire       chsp    = (i_paddr[11:7] == 5'h00);
////////////////////////////////////////////////////////////////////////
  // fixed-priority pick; lowest channel number wins
  function [2:0] pick;
    input [NCH-1:0] p;
    integer j;
    begin
      pick = 3'b000;
      for (j = NCH - 1; j >= 0; j = j - 1) begin
        if (p[j]) begin
          pick = {1'b1, j[1:0]};
        end
      end
    end
  endfunction
  // documented peripheral address for known request codes
  function [23:0] per_default;
    input [7:0]  code;
    input [15:0] pad;
    begin
      case (code)
        `FCD_IRQ_ADC_DONE: per_default = {8'h00, `FCD_PAD_ADC_BUF0};
        `FCD_IRQ_UART1_TX: per_default = {8'h00, `FCD_PAD_UART1_TX};
        default:           per_default = {8'h00, pad};
      endcase
    end
  endfunction

  // word slot of a register inside one channel block
  function [4:0] reg_slot;
    input [11:0] addr;
    begin
      reg_slot = {addr[4:2], 2'b00};
    end
  endfunction

  wire [2:0] win = pick(pend_q);

////////////////////////////////////////////////////////////////////////
  // winner and active-channel views, decoded once for the engine
  reg [1:0]     wch;
  reg [15:0]    wcon;
  reg           wperind;
  reg [23:0]    wram;
  reg [23:0]    wper;

  reg [15:0]    acon;
  reg           alive;
  reg           last_beat;
  reg           half_beat;
  reg [23:0]    astep;

  reg [NCH-1:0] hit;
  reg [NCH-1:0] live;
  integer       m;
  wire          wr_ch = apb_acc & i_pwrite & chsp & (ach < NCH);

  always @* begin
    wch       = win[1:0];
    wcon      = con_q[wch];
    wperind   = (wcon[`FCD_CON_ADDRESSING_SELECT_HI:`FCD_CON_ADDRESSING_SELECT_LO] == `FCD_ADDRESSING_SELECT_PERIND);
    wram      = wperind ? i_per_addr[wch*24 +: 24]
                        : ((pps_q[wch] ? stb_q[wch] : sta_q[wch]) + off_q[wch]);
    wper      = per_default(sel_q[wch], pad_q[wch]);
    acon      = con_q[act_q];
    // switching a channel off mid-transfer gives its bus slot back at once
    alive     = acon[`FCD_CON_ON];
    last_beat = (done_q[act_q] == cnt_q[act_q]);
    half_beat = acon[`FCD_CON_HALF] && (done_q[act_q] == {1'b0, cnt_q[act_q][13:1]});
    astep     = acon[`FCD_CON_SIZE] ? 24'h000001 : 24'h000002;
    hit       = {NCH{1'b0}};
    live      = {NCH{1'b0}};
    for (m = 0; m < NCH; m = m + 1) begin
      hit[m]  = i_irq_pulse[m] && (i_irq_code[m*8 +: 8] == sel_q[m]);
      live[m] = con_q[m][`FCD_CON_ON] && !stop_q[m];
    end
  end

////////////////////////////////////////////////////////////////////////
  // apb read mux
  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (chsp && (ach < NCH)) begin
      case (reg_slot(i_paddr))
        5'h00: rd_d[15:0] = con_q[ach];
        5'h04: rd_d[15:0] = {force_q[ach], 7'h00, sel_q[ach]};
        5'h08: rd_d[15:0] = sta_q[ach][15:0];
        5'h0C: rd_d[7:0]  = sta_q[ach][23:16];
        5'h10: rd_d[15:0] = stb_q[ach][15:0];
        5'h14: rd_d[7:0]  = stb_q[ach][23:16];
        5'h18: rd_d[15:0] = pad_q[ach];
        default: rd_d[13:0] = cnt_q[ach];
      endcase
    end else begin
      case (i_paddr)
        `FCD_OFF_PWC:   rd_d[NCH-1:0] = pwc_q;
        `FCD_OFF_RQC:   rd_d[NCH-1:0] = rqc_q;
        `FCD_OFF_PPS:   rd_d[NCH-1:0] = pps_q;
        `FCD_OFF_LCA:   rd_d[3:0]     = lca_q;
        `FCD_OFF_SADRL: rd_d[15:0]    = sadr_q[15:0];
        `FCD_OFF_SADRH: rd_d[7:0]     = sadr_q[23:16];
        default:        err_d = 1'b1;
      endcase
    end
  end
////////////////////////////////////////////////////////////////////////
  // apb answer: zero-wait, ready in the first access cycle
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      if (i_psel & ~i_penable) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_d;
        o_pslverr <= err_d;
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_mem_req <= 1'b0;
      o_mem_we  <= 1'b0;
      o_mem_byte <= 1'b0;
      o_mem_addr <= 24'h000000;
      o_mem_wdata <= 16'h0000;
      o_ch_irq  <= {NCH{1'b0}};
      pend_q <= {NCH{1'b0}};
      pps_q  <= {NCH{1'b0}};
      rqc_q  <= {NCH{1'b0}};
      pwc_q  <= {NCH{1'b0}};
      stop_q <= {NCH{1'b0}};
      lca_q  <= `FCD_LCA_RESET;
      sadr_q <= 24'h000000;
      st_q   <= S_IDLE;
      act_q  <= 2'h0;
      data_q <= 16'h0000;
      xa_q   <= 24'h000000;
      xdir_q <= 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        con_q[k]   <= 16'h0000;
        sel_q[k]   <= 8'h00;
        force_q[k] <= 1'b0;
        sta_q[k]   <= 24'h000000;
        stb_q[k]   <= 24'h000000;
        pad_q[k]   <= 16'h0000;
        cnt_q[k]   <= 14'h0000;
        done_q[k]  <= 14'h0000;
        off_q[k]   <= 24'h000000;
      end
    end else if (i_ce) begin
      o_ch_irq  <= {NCH{1'b0}};

      // requests; a peripheral request arriving while force is set is flagged
      for (k = 0; k < NCH; k = k + 1) begin
        if (live[k]) begin
          if (hit[k]) begin
            pend_q[k] <= 1'b1;
          end
          if (force_q[k] && !pend_q[k]) begin
            pend_q[k] <= 1'b1;
          end
          if (force_q[k] && hit[k]) begin
            rqc_q[k] <= 1'b1;
          end
        end else begin
          pend_q[k]  <= 1'b0;
          force_q[k] <= 1'b0;
          done_q[k]  <= 14'h0000;
          off_q[k]   <= 24'h000000;
          if (!con_q[k][`FCD_CON_ON]) begin
            stop_q[k] <= 1'b0;
          end
        end
      end
      if (i_per_wcol && (st_q == S_WR) && xdir_q) begin
        pwc_q[act_q] <= 1'b1;
      end
      // transfer engine: peripheral side, then memory side, or reverse
      case (st_q)
        S_IDLE: begin
          if (win[2]) begin
            act_q      <= wch;
            xdir_q     <= wcon[`FCD_CON_DIR];
            xa_q       <= wram;
            o_mem_req  <= 1'b1;
            o_mem_we   <= 1'b0;
            o_mem_byte <= wcon[`FCD_CON_SIZE];
            // the read phase goes to whichever side is the source
            if (wcon[`FCD_CON_DIR]) begin
              o_mem_addr <= wram;
            end else begin
              o_mem_addr <= wper;
            end
            st_q       <= S_RD;
          end
        end

        S_RD: begin
          if (!alive) begin
            o_mem_req <= 1'b0;
            st_q      <= S_IDLE;
          end else if (i_mem_gnt) begin
            data_q      <= i_mem_rdata;
            o_mem_we    <= 1'b1;
            o_mem_wdata <= (acon[`FCD_CON_NULL_WRITE_MODE] && !xdir_q) ? 16'h0000 : i_mem_rdata;
            o_mem_addr  <= xdir_q ? per_default(sel_q[act_q], pad_q[act_q]) : xa_q;
            st_q        <= S_WR;
          end
        end

        S_WR: begin
          if (!alive) begin
            o_mem_req <= 1'b0;
            o_mem_we  <= 1'b0;
            st_q      <= S_IDLE;
          end else if (i_mem_gnt) begin
            o_mem_req      <= 1'b0;
            o_mem_we       <= 1'b0;
            lca_q          <= {2'b00, act_q};
            sadr_q         <= xa_q;
            // a request arriving on the finishing edge is kept, not lost
            pend_q[act_q]  <= hit[act_q];
            force_q[act_q] <= 1'b0;
            st_q           <= S_IDLE;
            // no-increment mode leaves the offset untouched
            if (acon[`FCD_CON_ADDRESSING_SELECT_HI:`FCD_CON_ADDRESSING_SELECT_LO] == `FCD_ADDRESSING_SELECT_POSTINC) begin
              off_q[act_q] <= off_q[act_q] + astep;
            end

            if (last_beat) begin
              done_q[act_q]   <= 14'h0000;
              off_q[act_q]    <= 24'h000000;
              o_ch_irq[act_q] <= 1'b1;
              if (acon[`FCD_CON_MODE_HI]) begin
                pps_q[act_q] <= ~pps_q[act_q];
              end
              if (acon[`FCD_CON_MODE_LO]) begin
                stop_q[act_q] <= 1'b1;
              end
            end else begin
              done_q[act_q] <= done_q[act_q] + 14'h0001;
              if (half_beat) begin
                o_ch_irq[act_q] <= 1'b1;
              end
            end
          end
        end

        default: st_q <= S_IDLE;
      endcase
      // register writes; software may set force, and clears it only by writing control with on at zero

      if (wr_ch) begin
        case (reg_slot(i_paddr))
          5'h00: begin
            con_q[ach] <= i_pwdata[15:0] & `FCD_CON_MASK;
            if (!i_pwdata[`FCD_CON_ON]) begin
              force_q[ach] <= 1'b0;
            end
          end
          5'h04: begin
            sel_q[ach] <= i_pwdata[7:0];
            if (i_pwdata[`FCD_REQ_FORCE] && con_q[ach][`FCD_CON_ON]) begin
              force_q[ach] <= 1'b1;
            end
          end
          5'h08: sta_q[ach][15:0]  <= i_pwdata[15:0];
          5'h0C: sta_q[ach][23:16] <= i_pwdata[7:0];
          5'h10: stb_q[ach][15:0]  <= i_pwdata[15:0];
          5'h14: stb_q[ach][23:16] <= i_pwdata[7:0];
          5'h18: pad_q[ach] <= i_pwdata[15:0];
          default: cnt_q[ach] <= i_pwdata[13:0];
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** test/fcd_dma_asserts.sv ***
// port checker for the four-channel dma engine
`timescale 1ns/1ps
`default_nettype none
module fcd_dma_asserts #(
  parameter NCH = 4
) (
  input wire logic           i_clk,
  input wire logic           i_reset_n,
  input wire logic           i_psel,
  input wire logic           i_penable,
  input wire logic           o_pready,
  input wire logic           o_pslverr,
  input wire logic           o_mem_req,
  input wire logic           o_mem_we,
  input wire logic [23:0]    o_mem_addr,
  input wire logic           i_mem_gnt,
  input wire logic [NCH-1:0] o_ch_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////
  ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  ready_in_access_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access");
  error_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  // an aborted channel may drop its request, but never move it
  mem_hold_a: assert property (o_mem_req && !i_mem_gnt |=>
    !o_mem_req || ($stable(o_mem_addr) && $stable(o_mem_we)))
    else $error("request moved while stalled");
  read_then_write_a: assert property (o_mem_req && !o_mem_we && i_mem_gnt |=>
    o_mem_req && o_mem_we)
    else $error("no write after read");
  write_release_a: assert property (o_mem_req && o_mem_we && i_mem_gnt |=> !o_mem_req)
    else $error("request kept after write");
  irq_single_a: assert property (|o_ch_irq |=> o_ch_irq == '0)
    else $error("irq longer than a cycle");
  irq_after_write_a: assert property (|o_ch_irq |->
    $past(o_mem_req && o_mem_we && i_mem_gnt))
    else $error("irq without a finished write");
  cover property (o_mem_req && o_mem_we && i_mem_gnt);
  cover property (|o_ch_irq);
  cover property (o_pslverr);
endmodule
bind fcd_dma fcd_dma_asserts #(.NCH(NCH)) u_chk (.i_clk, .i_reset_n, .i_psel, .i_penable,
  .o_pready, .o_pslverr, .o_mem_req, .o_mem_we, .o_mem_addr, .i_mem_gnt, .o_ch_irq);
`default_nettype wire

// *** test/fcd_mem_model.sv ***
// sram arbiter model shared with a busy cpu
`timescale 1ns/1ps
`default_nettype none
module fcd_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_hold,
  input  wire logic [23:0] i_addr,
  output logic             o_gnt,
  output logic [15:0]      o_rdata
);
  logic [1:0] cnt_q = 2'h0;
  always_ff @(posedge i_clk) begin
    cnt_q <= cnt_q + 2'h1;
  end
  // cpu owns the bus every other cycle, or all along on hold
  assign o_gnt = i_req && !i_hold && cnt_q[0];
  // data only meaningful with grant; otherwise a moving pattern
  assign o_rdata = o_gnt ? (i_addr[15:0] ^ 16'h5A5A) : {14'h3FFF, ~cnt_q};
endmodule
`default_nettype wire

// *** test/tb_fcd_dma.sv ***
// self-checking bench of the four-channel dma engine
`timescale 1ns/1ps
`default_nettype none
`include "fcd_defs.vh"
`define CHK(n, x, s) begin compares++; if ((s) !== (x)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, x, s); end end
module tb_fcd_dma;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, hold = 0, ce = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, icode = 0;
  logic        pready, pslverr, e, req, we, byt, gnt;
  logic [3:0]  ipulse = 0, irq;
  logic [95:0] peraddr = 0;
  logic [23:0] maddr, sta, pa, a;
  logic [15:0] wdata, rdata, pad;
  int          num_errors = 0, compares = 0, seed = 70, xfers = 0;
  int          irqs [4] = '{0, 0, 0, 0};
  logic [23:0] rq [$], wq [$];
  logic [15:0] dq [$];
  logic        bq [$];
  fcd_dma dut_u (.i_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_irq_code(icode),
    .i_irq_pulse(ipulse), .i_per_addr(peraddr), .i_per_wcol(1'b0), .o_mem_req(req),
    .o_mem_we(we), .o_mem_byte(byt), .o_mem_addr(maddr), .o_mem_wdata(wdata),
    .i_mem_gnt(gnt), .i_mem_rdata(rdata), .o_ch_irq(irq));
  fcd_mem_model mem_u (.i_clk(clk), .i_req(req), .i_hold(hold), .i_addr(maddr),
    .o_gnt(gnt), .o_rdata(rdata));
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (req && gnt && !we) rq.push_back(maddr);
    if (req && gnt && we) begin
      wq.push_back(maddr); dq.push_back(wdata); bq.push_back(byt); xfers++;
    end
    for (int k = 0; k < 4; k++) irqs[k] += irq[k];
  end
  task automatic apb(input logic w, input logic [11:0] ad, input logic [15:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= {16'h0, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [11:0] ad, input logic [31:0] x);
    apb(0, ad, 16'h0); `CHK("register", x, r)
  endtask
  task automatic waitx(input int n);
    repeat (400) if (xfers < n) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  // control written last so the channel is never live while set up
  task automatic cfg(input logic [11:0] c, input logic [15:0] con, input logic [7:0] code,
                     input logic [23:0] s, input logic [15:0] p, input logic [13:0] n);
    logic [11:0] b;
    b = c * `FCD_CH_STRIDE;
    apb(1, b + `FCD_OFF_STAL, s[15:0]);
    apb(1, b + `FCD_OFF_STAH, {8'h0, s[23:16]});
    apb(1, b + `FCD_OFF_PAD, p);
    apb(1, b + `FCD_OFF_CNT, {2'h0, n});
    apb(1, b + `FCD_OFF_REQ, {8'h0, code});
    apb(1, b + `FCD_OFF_CON, con);
  endtask
  task automatic pulse(input logic [3:0] m);
    ipulse <= m; @(posedge clk); ipulse <= 0; @(posedge clk);
  endtask
  task automatic onex(input logic [15:0] con, input logic [7:0] code,
                      input logic [23:0] x, input logic w);
    rq.delete(); wq.delete(); icode[31:24] <= code;
    cfg(3, con, code, 24'h0, 16'h0, 14'h0);
    pulse(4'h8); waitx(xfers + 1);
    `CHK("target", x, w ? wq[0] : rq[0])
    apb(1, 12'h060, 16'h0);
  endtask
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // all tests need well under 10k cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++; conclude();
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    rdchk(`FCD_OFF_LCA, 32'hF);
    rdchk(`FCD_OFF_PPS, 32'h0);
    rdchk(12'h0FC, 32'h0);
    `CHK("slverr", 1'b1, e)
    apb(1, `FCD_OFF_STAH, 16'hFFFF);
    rdchk(`FCD_OFF_STAH, 32'hFF);
    apb(1, `FCD_OFF_CNT, 16'hFFFF);
    rdchk(`FCD_OFF_CNT, 32'h3FFF);
    apb(1, `FCD_OFF_CON, 16'h7FFF);
    rdchk(`FCD_OFF_CON, 32'h7833);
    apb(1, `FCD_OFF_REQ, 16'h00FF);
    rdchk(`FCD_OFF_REQ, 32'hFF);
    $display("test registers done");
    sta = 24'($random(seed)) & 24'hFFFFFE; pad = 16'($random(seed));
    cfg(0, 16'hA000, 8'hFF, sta, pad, 14'h2);
    for (int k = 0; k < 3; k++) begin
      apb(1, `FCD_OFF_REQ, 16'h80FF);
      waitx(k + 1);
      a = sta + 24'(2 * k);
      `CHK("read addr", a, rq.pop_front())
      `CHK("write addr", {8'h0, pad}, wq.pop_front())
      `CHK("data", a[15:0] ^ 16'h5A5A, dq.pop_front())
      `CHK("block irq", (k == 2) ? 1 : 0, irqs[0])
    end
    rdchk(`FCD_OFF_REQ, 32'hFF);
    rdchk(`FCD_OFF_LCA, 32'h0);
    $display("test forced block done");
    rq.delete(); wq.delete(); bq.delete();
    icode <= {8'h00, 8'h22, 8'h46, 8'hFF};
    cfg(1, 16'hE010, 8'h46, sta, 16'h0A00, 14'h1);
    cfg(2, 16'hA003, 8'h22, sta, 16'h0B00, 14'h0);
    pulse(4'h6); waitx(5);
    `CHK("first write", 24'h000A00, wq.pop_front())
    `CHK("byte size", 1'b1, bq[0])
    `CHK("pending write", 24'h000B00, wq.pop_front())
    pulse(4'h2); waitx(6);
    `CHK("fixed addr a", sta, rq[0])
    `CHK("fixed addr b", sta, rq[2])
    `CHK("irq ch1", 1, irqs[1])
    `CHK("irq ch2", 1, irqs[2])
    rdchk(`FCD_OFF_PPS, 32'h4);
    rdchk(`FCD_OFF_LCA, 32'h1);
    $display("test priority done");
    ce <= 0;
    pulse(4'h2);
    ce <= 1;
    pulse(4'h4);
    repeat (20) @(posedge clk);
    `CHK("frozen and stopped", 6, xfers)
    $display("test freeze done");
    pa = 24'($random(seed)) & 24'hFFFFFE;
    peraddr[95:72] <= pa;
    onex(16'hA000, `FCD_IRQ_UART1_TX, 24'h000224, 1'b1);
    onex(16'h8000, `FCD_IRQ_ADC_DONE, 24'h000300, 1'b0);
    onex(16'h8020, 8'h33, pa, 1'b1);
    $display("test request table done");
    hold <= 1;
    cfg(3, 16'h8000, 8'h33, 24'h0, 16'h0, 14'h0);
    apb(1, 12'h064, 16'h8033);
    rdchk(12'h064, 32'h8033);
    pulse(4'h8);
    rdchk(`FCD_OFF_RQC, 32'h8);
    apb(1, 12'h060, 16'h0);
    rdchk(12'h064, 32'h33);
    `CHK("abort", 1'b0, req)
    hold <= 0;
    $display("test disable done");
    conclude();
  end
endmodule
`default_nettype wire
